// *** timed_port_pkg.sv ***
package timed_port_pkg;
  // ************************
  // Port and pin arrangement
  // ************************
  localparam int NPORT = 5;
  localparam int NCB   = 6;
  localparam int NPIN  = 32;
  localparam int CNT_W = 16;
  localparam int PORT_W    [NPORT] = '{1, 4, 8, 16, 32};
  localparam int PORT_BASE [NPORT] = '{0, 4, 0, 0, 0};
  localparam int LINK_LO = 28;
  localparam int LINK_HI = 31;
  localparam logic [2:0] NO_OWNER = 3'h7;

  // ***************
  // Reference clock
  // ***************
  localparam int CLK_MHZ = 100;
  localparam int REF_MHZ = 100;
  localparam logic [7:0] REF_DIV = 8'(CLK_MHZ / REF_MHZ - 1);

  // ************
  // Register map
  // ************
  localparam logic [3:0] R_CTRL  = 4'h0;
  localparam logic [3:0] R_DATA  = 4'h4;
  localparam logic [3:0] R_TIME  = 4'h8;
  localparam logic [3:0] R_STAMP = 4'hC;
  localparam logic [7:0] OFS_STATUS = 8'h80;
  localparam logic [7:0] OFS_MASK   = 8'h84;
  localparam logic [7:0] OFS_LINK   = 8'h88;
  localparam logic [2:0] CB_PAGE    = 3'h5;
  localparam logic [31:0] CTRL_RESET = 32'h0;

  // Control fields of a port
  localparam int C_EN    = 0;
  localparam int C_OUT   = 1;
  localparam int C_OD    = 2;
  localparam int C_COND  = 3;
  localparam int C_TIMED = 4;
  localparam int C_STB   = 5;
  localparam int C_CLK   = 8;
  // Clock block config fields
  localparam int CB_SRC = 0;
  localparam int CB_DIV = 8;
endpackage

// *** timed_port.sv ***
`timescale 1ns/1ns
// Overview of operation
// - Each port has one direction bit; all its pins go the same way.
// - Ports of 1, 4, 8, 16, 32 pins, each at its own width.
// - Drive pins, or sample them, optionally until a match value appears.
// - Every register access completes with no wait states.
// - Open-drain option per port: zero drives low, one releases the pin.
// - Output data passes through a transfer register and a serdes stage; input data goes straight to the transfer register.
// - A 16-bit port counter can time the transfer moment.
// - Port counter readable at any time; compare value delays transfers.
// - Each transfer stores the counter as a readable timestamp.
// - Enabled link takes its shared pins from all ports.
// - Narrower enabled port wins shared pins; wider keeps the rest.
// - Port transfers are delivered as direct event pulses.
// - Six clock blocks; block 0 is the 100 MHz reference.
// - Blocks 1 to 5 may tick from the 1-bit port, divided.
// - Strobe in qualifies input data; strobe out marks output data.
// - After reset every port uses clock block 0.
// - A wait ends on a port event, including a timed one.
module timed_port
  import timed_port_pkg::*;
(
  input  wire logic                            hclk,
  input  wire logic                            hresetn,
  input  wire logic                            hsel,
  input  wire logic [31:0]                     haddr,
  input  wire logic [1:0]                      htrans,
  input  wire logic                            hwrite,
  input  wire logic [2:0]                      hsize,
  input  wire logic                            hready,
  input  wire logic [31:0]                     hwdata,
  output logic      [31:0]                     hrdata,
  output wire logic                            hreadyout,
  output wire logic                            hresp,
  input  wire logic [timed_port_pkg::NPIN-1:0] pin_in,
  output logic      [timed_port_pkg::NPIN-1:0] pin_out,
  output logic      [timed_port_pkg::NPIN-1:0] pin_oe_n,
  input  wire logic [timed_port_pkg::NPORT-1:0] strobe_in,
  output logic      [timed_port_pkg::NPORT-1:0] strobe_out,
  output wire logic [timed_port_pkg::NPORT-1:0] port_event,
  output wire logic                            irq
);
  import timed_port_pkg::*;

  // **************
  // Shared storage
  // **************
  logic [31:0]      ctrl  [NPORT];
  logic [31:0]      xfer  [NPORT];
  logic [31:0]      cond  [NPORT];
  logic [31:0]      shreg [NPORT];
  logic [CNT_W-1:0] cnt   [NPORT];
  logic [CNT_W-1:0] tcmp  [NPORT];
  logic [CNT_W-1:0] stamp [NPORT];
  logic [15:0]      cb_cfg [NCB];
  logic [NPORT-1:0] pending;
  logic [NPORT-1:0] full;
  logic [NPORT-1:0] go;
  logic [NPORT-1:0] tk_v;
  logic [NPORT-1:0] stb1;
  logic [NPORT-1:0] out_v;
  logic [NPORT-1:0] od_v;
  logic [NPORT-1:0] status;
  logic [NPORT-1:0] mask;
  logic [NPORT-1:0][NPIN-1:0] own;
  logic [NPORT-1:0][NPIN-1:0] placed;
  logic [NCB-1:0]   tick;
  logic             link_en;
  logic             wr_pend;
  logic [7:0]       wr_addr;
  logic             pin0_q;
  logic             boot;
  logic [NPIN+NPORT-1:0] m1;
  logic [NPIN+NPORT-1:0] m2;
  logic [NPIN+NPORT-1:0] m3;
  logic [NPIN+NPORT-1:0] mst;

  // *************
  // AHB-Lite decode
  // *************
  // Zero wait states: every access ends in its first data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  wire       acc    = hsel & htrans[1] & hready;
  wire [2:0] a_port = haddr[6:4];
  wire [2:0] a_cb   = haddr[4:2];
  wire [2:0] w_port = wr_addr[6:4];
  wire [2:0] w_cb   = wr_addr[4:2];
  wire       w_glob = wr_pend & wr_addr[7];
  wire       w_loc  = wr_pend & ~wr_addr[7];
  wire       wr_stat = w_glob & (wr_addr == OFS_STATUS);
  wire       wr_mask = w_glob & (wr_addr == OFS_MASK);
  wire       wr_link = w_glob & (wr_addr == OFS_LINK);
  wire       wr_cb   = w_glob & (wr_addr[7:5] == CB_PAGE)
                       & (w_cb != 3'h0) & (w_cb < 3'(NCB));
  wire [NPORT-1:0] w1c = wr_stat ? hwdata[NPORT-1:0] : '0;
  wire [7:0] tick8 = 8'(tick);

  // Read selection from the address phase
  wire [31:0] port_rd =
    (a_port >= 3'(NPORT))  ? 32'h0 :
    (haddr[3:0] == R_CTRL) ? ctrl[a_port] :
    (haddr[3:0] == R_DATA) ? xfer[a_port] :
    (haddr[3:0] == R_TIME) ? 32'(cnt[a_port]) :
                             32'(stamp[a_port]);
  wire [31:0] glob_rd =
    (haddr[7:0] == OFS_STATUS) ? 32'(status) :
    (haddr[7:0] == OFS_MASK)   ? 32'(mask) :
    (haddr[7:0] == OFS_LINK)   ? 32'(link_en) :
    ((haddr[7:5] == CB_PAGE) && (a_cb < 3'(NCB)))
                               ? 32'(cb_cfg[a_cb]) : 32'h0;
  wire [31:0] rd_mux = haddr[7] ? glob_rd : port_rd;

  // Interrupt line and direct event pulses
  assign irq        = |(status & mask);
  assign port_event = go;

  // Bus phase, status, config and pin synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h0;
      status  <= '0;
      mask    <= '0;
      link_en <= 1'b0;
      pin0_q  <= 1'b0;
      boot    <= 1'b1;
      m1      <= '0;
      m2      <= '0;
      m3      <= '0;
      mst     <= '0;
    end else begin
      wr_pend <= acc & hwrite;
      boot    <= 1'b0;
      if (acc) begin
        wr_addr <= haddr[7:0];
      end
      if (acc & ~hwrite) begin
        hrdata <= rd_mux;
      end
      // Set wins over a write-one clear in the same cycle
      status <= (status & ~w1c) | go;
      if (wr_mask) begin
        mask <= hwdata[NPORT-1:0];
      end
      if (wr_link) begin
        link_en <= hwdata[0];
      end
      m1  <= {strobe_in, pin_in};
      m2  <= m1;
      m3  <= m2;
      // A change counts once the second and third stage agree
      mst <= (m2 & m3) | (mst & (m2 ^ m3));
      pin0_q <= mst[0];
    end
  end

  // Clock block config; block 0 is fixed to the reference
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < NCB; k++) begin
        cb_cfg[k] <= 16'h0000;
      end
    end else if (wr_cb) begin
      cb_cfg[w_cb] <= hwdata[15:0];
    end
  end

  // ************
  // Clock blocks
  // ************
  wire pin0_rise = mst[0] & ~pin0_q;
  for (genvar k = 0; k < NCB; k++) begin : g_cb
    logic [7:0] div_cnt;
    // Block 0 divides hclk down to the reference rate
    wire [7:0] div = (k == 0) ? REF_DIV : cb_cfg[k][CB_DIV+:8];
    wire       ext = (k != 0) & cb_cfg[k][CB_SRC];
    wire       src = ext ? pin0_rise : 1'b1;
    assign tick[k] = src & (div_cnt >= div);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        div_cnt <= 8'h00;
      end else if (src) begin
        div_cnt <= tick[k] ? 8'h00 : div_cnt + 8'h01;
      end
    end
  end

  // *****
  // Ports
  // *****
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    localparam logic [31:0] WMASK = 32'((64'h1 << PORT_W[p]) - 64'h1);
    wire       en    = ctrl[p][C_EN];
    wire       out_m = ctrl[p][C_OUT];
    wire [2:0] sel   = ctrl[p][C_CLK+:3];
    wire       tk    = en & tick8[sel];
    wire       at_t  = ~ctrl[p][C_TIMED] | (cnt[p] == tcmp[p]);
    // Pins taken by a narrower port or the link read as zero
    wire [31:0] smp  = ((mst[NPIN-1:0] & own[p]) >> PORT_BASE[p]) & WMASK;
    wire       hit   = (~ctrl[p][C_COND] | (smp == cond[p]))
                     & (~ctrl[p][C_STB] | mst[NPIN+p]);
    wire       sel_p = (w_port == 3'(p));
    wire       wc    = w_loc & sel_p & (wr_addr[3:0] == R_CTRL);
    wire       wd    = w_loc & sel_p & (wr_addr[3:0] == R_DATA);
    wire       wt    = w_loc & sel_p & (wr_addr[3:0] == R_TIME);
    wire       rclr  = acc & ~hwrite & ~haddr[7]
                     & (a_port == 3'(p)) & (haddr[3:0] == R_DATA);
    assign tk_v[p]   = tk;
    assign out_v[p]  = en & out_m;
    assign od_v[p]   = ctrl[p][C_OD];
    assign placed[p] = shreg[p] << PORT_BASE[p];
    assign go[p]     = tk & at_t & (out_m ? pending[p] : hit & ~full[p]);

    // Transfer register, serdes stage, counter and stamp
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ctrl[p]    <= CTRL_RESET;
        xfer[p]    <= 32'h0;
        cond[p]    <= 32'h0;
        shreg[p]   <= 32'h0;
        cnt[p]     <= '0;
        tcmp[p]    <= '0;
        stamp[p]   <= '0;
        pending[p] <= 1'b0;
        full[p]    <= 1'b0;
        stb1[p]    <= 1'b0;
        strobe_out[p] <= 1'b0;
      end else begin
        if (wc) begin
          ctrl[p] <= hwdata;
        end
        if (wt) begin
          tcmp[p] <= hwdata[CNT_W-1:0];
        end
        if (tk) begin
          cnt[p] <= cnt[p] + 16'h0001;
        end
        // A new word wins over the one leaving this cycle
        if (wd & out_m) begin
          xfer[p]    <= hwdata & WMASK;
          pending[p] <= 1'b1;
        end else if (go[p] & out_m) begin
          pending[p] <= 1'b0;
        end
        if (wd & ~out_m) begin
          cond[p] <= hwdata & WMASK;
        end
        if (go[p]) begin
          stamp[p] <= cnt[p];
          if (out_m) begin
            shreg[p] <= xfer[p];
          end else begin
            xfer[p] <= smp;
          end
        end
        if (go[p] & ~out_m) begin
          full[p] <= 1'b1;
        end else if (rclr | wd) begin
          full[p] <= 1'b0;
        end
        // Strobe passes two stages, so it rises with the pin register
        stb1[p]       <= go[p] & out_m & ctrl[p][C_STB];
        strobe_out[p] <= stb1[p];
      end
    end

    sequence out_fire;
      go[p] && out_m;
    endsequence
    sequence stb_pair;
      ##1 stb1[p] ##1 strobe_out[p];
    endsequence
    step_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
      tk |=> cnt[p] == $past(cnt[p]) + 16'h0001)
      else $error("port counter did not step on tick");
    stamp_take_a: assert property (@(posedge hclk) disable iff (!hresetn)
      go[p] |=> stamp[p] == $past(cnt[p]))
      else $error("timestamp not captured on transfer");
    timed_go_a: assert property (@(posedge hclk) disable iff (!hresetn)
      go[p] && ctrl[p][C_TIMED] |-> cnt[p] == tcmp[p])
      else $error("timed transfer off its count");
    strobe_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
      out_fire and ctrl[p][C_STB] |-> stb_pair)
      else $error("output strobe missing");
    boot_clock_a: assert property (@(posedge hclk) disable iff (!hresetn)
      boot |-> sel == 3'h0)
      else $error("port not on clock block 0 after reset");
    event_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
      go[p] |=> status[p])
      else $error("event not latched");
  end

  // ***************
  // Pin arbitration
  // ***************
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    logic [2:0] own_i;
    logic [7:0] v8;
    // Narrowest enabled port claims the pin; link overrides all
    always_comb begin
      own_i = NO_OWNER;
      for (int p = NPORT - 1; p >= 0; p--) begin
        if (ctrl[p][C_EN] && i >= PORT_BASE[p]
            && i < PORT_BASE[p] + PORT_W[p]) begin
          own_i = 3'(p);
        end
      end
      if (link_en && i >= LINK_LO && i <= LINK_HI) begin
        own_i = NO_OWNER;
      end
    end
    for (genvar p = 0; p < NPORT; p++) begin : g_own
      assign own[p][i] = (own_i == 3'(p));
      assign v8[p]     = placed[p][i];
    end
    assign v8[7:NPORT] = '0;
    wire [7:0] out8 = 8'(out_v);
    wire [7:0] od8  = 8'(od_v);
    wire drv = out8[own_i];
    wire od  = od8[own_i];
    wire val = v8[own_i];
    // Registered so the pads never see decode glitches
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pin_out[i]  <= 1'b0;
        pin_oe_n[i] <= 1'b1;
      end else begin
        pin_out[i]  <= drv & ~od & val;
        pin_oe_n[i] <= ~drv | (od & val);
      end
    end

    od_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
      drv && od && val |=> pin_oe_n[i] && !pin_out[i])
      else $error("open-drain pin driven high");
  end

  link_pins_a: assert property (@(posedge hclk) disable iff (!hresetn)
    link_en |=> &pin_oe_n[LINK_HI:LINK_LO])
    else $error("port drives a link pin");
  narrow_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl[0][C_EN] && !link_en |-> g_pin[0].own_i == 3'h0)
    else $error("wider port took a shared pin");
  ref_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tick[0] [*4])
    else $error("reference block missed a tick");
  status_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    acc && !hwrite && haddr[7:0] == OFS_STATUS && !wr_pend
    |=> hreadyout && hrdata == 32'($past(status)))
    else $error("status read wrong");
endmodule

// *** pin_partner.sv ***
`timescale 1ns/1ns
// ******************************
// External hardware on the pins
// ******************************
module pin_partner
  import timed_port_pkg::*;
(
  input  wire logic [timed_port_pkg::NPIN-1:0]  pin_out,
  input  wire logic [timed_port_pkg::NPIN-1:0]  pin_oe_n,
  input  wire logic [timed_port_pkg::NPIN-1:0]  ext_val,
  input  wire logic [timed_port_pkg::NPIN-1:0]  ext_en,
  input  wire logic [timed_port_pkg::NPORT-1:0] ext_stb,
  output logic      [timed_port_pkg::NPIN-1:0]  pin_in,
  output logic      [timed_port_pkg::NPORT-1:0] strobe_in
);
  import timed_port_pkg::*;
  // Device drive wins; a released, undriven pin sits at the pull-down
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] & ext_val[i]);
    end
  end
  // Our strobe qualifies the data we present
  assign strobe_in = ext_stb;
endmodule

// *** timed_port_test.sv ***
`timescale 1ns/1ns
module timed_port_test;
  import timed_port_pkg::*;
  // ********************
  // Signals and counters
  // ********************
  logic        hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, ext_val, ext_en, pin_in, pin_out;
  logic [31:0] pin_oe_n, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  ext_stb, strobe_in, strobe_out, port_event;
  logic        hreadyout, hresp, irq, hit;
  logic [15:0] t0;
  int          n_fail, check_count;
  wire         hready = hreadyout;

  timed_port i_timed_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .strobe_in(strobe_in),
    .strobe_out(strobe_out), .port_event(port_event), .irq(irq));
  pin_partner i_pin_partner (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_val(ext_val), .ext_en(ext_en), .ext_stb(ext_stb),
    .pin_in(pin_in), .strobe_in(strobe_in));

  // *************
  // Shared tasks
  // *************
  function automatic logic [31:0] pa(input int p, input logic [3:0] r);
    pa = {24'h0, 4'(p), r};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Bus cycles start right after a rising edge and hold until ready
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= 1'b1;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= 1'b0;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [31:0] a,
                      input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask
  // Bounded wait on an event pulse or a strobe pulse, sampled mid-cycle
  task automatic wait_ev(input int p, input logic stb, input int lim);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(negedge hclk);
      if ((stb ? strobe_out[p] : port_event[p]) === 1'b1) hit = 1'b1;
    end
    @(posedge hclk);
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // *****************
  // Clock and watchdog
  // *****************
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // A few hundred cycles are expected; far beyond means a hang
  initial begin
    #50000;
    n_fail++;
    finish_test();
  end

  // *********
  // Sequence
  // *********
  initial begin
    {hresetn, hwrite, htrans, haddr, hwdata} = '0;
    {ext_val, ext_en, ext_stb, n_fail, check_count} = '0;
    hsel = 1'b1;
    hsize = 3'h2;
    cyc(2);
    hresetn <= 1'b1;
    chk("oe_rst", 32'hFFFFFFFF, pin_oe_n);
    rchk("ctrl0_rst", pa(0, R_CTRL), CTRL_RESET);
    rchk("unmapped", 32'h00000060, 32'h0);
    chk("hready", 32'h1, 32'(hreadyout));
    chk("hresp", 32'h0, 32'(hresp));
    // Block 1 from pin 0, divided by two: six rising edges, three ticks
    wr(32'h000000A4, 32'h00000101);
    wr(pa(3, R_CTRL), 32'h00000101);
    ext_en <= 32'h0000FF01;
    rd(pa(3, R_TIME), v);
    t0 = v[15:0];
    repeat (12) begin
      cyc(4);
      ext_val[0] <= ~ext_val[0];
    end
    cyc(8);
    rchk("cb1_ticks", pa(3, R_TIME), 32'(t0 + 16'h3));
    // Reference counter: reads start three edges apart
    wr(pa(3, R_CTRL), 32'h00000029);
    rd(pa(3, R_TIME), v);
    t0 = v[15:0];
    rchk("ref_ticks", pa(3, R_TIME), 32'(t0 + 16'h3));
    // Input waits for match and for the external strobe
    ext_val <= 32'h00001100;
    ext_stb <= 5'h08;
    wr(pa(3, R_DATA), 32'h00003C00);
    wait_ev(3, 1'b0, 12);
    chk("no_match", 32'h0, 32'(hit));
    ext_stb <= 5'h00;
    ext_val <= 32'h00003C00;
    wait_ev(3, 1'b0, 12);
    chk("no_strobe", 32'h0, 32'(hit));
    ext_stb <= 5'h08;
    wait_ev(3, 1'b0, 12);
    chk("in_event", 32'h1, 32'(hit));
    rchk("in_data", pa(3, R_DATA), 32'h00003C00);
    wr(pa(3, R_CTRL), 32'h0);
    ext_en <= 32'h0;
    // Timed output on port 2 with strobe, data wider than the port
    wr(OFS_STATUS, 32'h0000001F);
    wr(pa(2, R_CTRL), 32'h00000033);
    rd(pa(2, R_TIME), v);
    t0 = v[15:0] + 16'd40;
    wr(pa(2, R_TIME), 32'(t0));
    wr(pa(2, R_DATA), 32'h000001A5);
    wait_ev(2, 1'b0, 60);
    chk("timed_ev", 32'h1, 32'(hit));
    wait_ev(2, 1'b1, 4);
    chk("strobe_out", 32'h1, 32'(hit));
    chk("out_val", 32'hA5, 32'(pin_out[7:0]));
    chk("out_oe", 32'h0, 32'(pin_oe_n[7:0]));
    rchk("stamp", pa(2, R_STAMP), 32'(t0));
    // Sticky status, mask and level interrupt
    rchk("status", OFS_STATUS, 32'h00000004);
    chk("irq_masked", 32'h0, 32'(irq));
    wr(OFS_MASK, 32'h00000004);
    @(negedge hclk);
    chk("irq_on", 32'h1, 32'(irq));
    wr(OFS_STATUS, 32'h00000004);
    @(negedge hclk);
    chk("irq_off", 32'h0, 32'(irq));
    // Narrow open-drain port takes pins 4..7 from port 2
    wr(pa(1, R_CTRL), 32'h00000007);
    wr(pa(1, R_DATA), 32'h00000005);
    wait_ev(1, 1'b0, 4);
    chk("od_ev", 32'h1, 32'(hit));
    cyc(2);
    chk("od_oe", 32'h5, 32'(pin_oe_n[7:4]));
    chk("od_low", 32'h0, 32'(pin_out[7:4] & 4'hA));
    chk("wide_keep", 32'h0, 32'(pin_oe_n[3:0]));
    // Link owns pins 28..31 ahead of the 32-pin port
    wr(OFS_LINK, 32'h00000001);
    wr(pa(4, R_CTRL), 32'h00000003);
    wr(pa(4, R_DATA), 32'hFFFFFFFF);
    wait_ev(4, 1'b0, 4);
    chk("link_ev", 32'h1, 32'(hit));
    cyc(2);
    chk("link_pins", 32'hF, 32'(pin_oe_n[31:28]));
    chk("wide_pins", 32'h0, 32'(pin_oe_n[27:8]));
    chk("wide_val", 32'hFFFFF, 32'(pin_out[27:8]));
    finish_test();
  end
endmodule
